// ### spod_cfg.svh
`ifndef SPOD_CFG_SVH
`define SPOD_CFG_SVH
// segment override prefix pattern: 001x_x110
`define SPOD_PFX_HI_MSB     7
`define SPOD_PFX_HI_LSB     5
`define SPOD_PFX_HI_VAL     3'h1
`define SPOD_PFX_LO_MSB     2
`define SPOD_PFX_LO_LSB     0
`define SPOD_PFX_LO_VAL     3'h6
`define SPOD_SEL_MSB        4
`define SPOD_SEL_LSB        3
// operand address byte fields
`define SPOD_MOD_MSB        7
`define SPOD_MOD_LSB        6
`define SPOD_AUX_MSB        5
`define SPOD_AUX_LSB        3
`define SPOD_RM_MSB         2
`define SPOD_RM_LSB         0
`define SPOD_MOD_REG        2'h3
`define SPOD_MOD_D8         2'h1
`define SPOD_MOD_D16        2'h2
`define SPOD_MOD_NODISP     2'h0
`define SPOD_RM_DIRECT      3'h6
`define SPOD_W_BIT          0
`define SPOD_SIGN_BIT       7
`define SPOD_STR_DIR_BIT    3
// byte counts of the trailing operand fields
`define SPOD_CB_BYTES       3'h1
`define SPOD_CD_BYTES       3'h4
`define SPOD_DISP8_BYTES    2'h1
`define SPOD_DISP16_BYTES   2'h2
`define SPOD_ES_CODE        2'h0
`define SPOD_DS_CODE        2'h3
`define SPOD_SI_REG         3'h6
`define SPOD_DI_REG         3'h7
`endif

// ### spod_pkg.sv
package spod_pkg;
	typedef enum logic [1:0] {
		SPOD_SEG_EXTRA = 2'b00,
		SPOD_SEG_CODE  = 2'b01,
		SPOD_SEG_STACK = 2'b10,
		SPOD_SEG_DATA  = 2'b11
	} spod_seg_type;

	typedef enum logic [2:0] {
		SPOD_ROLE_NONE   = 3'b000,
		SPOD_ROLE_PREFIX = 3'b001,
		SPOD_ROLE_OPCODE = 3'b010,
		SPOD_ROLE_MODRM  = 3'b011,
		SPOD_ROLE_DISP   = 3'b100,
		SPOD_ROLE_IMM    = 3'b101,
		SPOD_ROLE_OFFSET = 3'b110
	} spod_role_type;

	// operand class, supplied by the opcode table upstream
	typedef enum logic [2:0] {
		SPOD_OPC_NONE  = 3'b000,
		SPOD_OPC_EXT   = 3'b001,
		SPOD_OPC_REG   = 3'b010,
		SPOD_OPC_EMBED = 3'b011,
		SPOD_OPC_CB    = 3'b100,
		SPOD_OPC_CD    = 3'b101,
		SPOD_OPC_STR   = 3'b110
	} spod_opclass_type;

	typedef enum logic [2:0] {
		SPOD_ST_OPCODE = 3'b000,
		SPOD_ST_MODRM  = 3'b001,
		SPOD_ST_DISP   = 3'b010,
		SPOD_ST_IMM    = 3'b011,
		SPOD_ST_OFFSET = 3'b100,
		SPOD_ST_DONE   = 3'b101
	} spod_state_type;
endpackage : spod_pkg

// ### spod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "spod_cfg.svh"
module spod_decoder (
	input  wire logic                   MCLK,
	input  wire logic                   RST_B,
	input  wire logic                   BYTE_VALID,
	input  wire logic [7:0]             BYTE_DATA,
	input  wire spod_pkg::spod_opclass_type OP_CLASS,
	input  wire logic                   OP_HAS_MODRM,
	input  wire logic [1:0]             OP_IMM_BYTES,
	input  wire logic                   OP_IMM_SIGNED,
	output var  spod_pkg::spod_role_type BYTE_ROLE,
	output logic                        BYTE_ROLE_VALID,
	output var  spod_pkg::spod_seg_type SEG_SEL,
	output logic                        SEG_OVERRIDE,
	output logic [7:0]                  OPCODE,
	output logic [1:0]                  MOD_FIELD,
	output logic [2:0]                  AUX_FIELD,
	output logic [2:0]                  RM_FIELD,
	output logic [2:0]                  OPCODE_EXT,
	output logic                        OPCODE_EXT_VALID,
	output logic [2:0]                  REG_SEL,
	output logic                        REG_SEL_VALID,
	output logic                        REG_WORD,
	output logic [15:0]                 DISP,
	output logic [15:0]                 IMM,
	output logic [31:0]                 OFFSET,
	output logic                        INSN_DONE
);
	import spod_pkg::*;

	spod_state_type state;
	spod_opclass_type opc;
	logic [1:0]  imm_left;
	logic [1:0]  imm_total;
	logic        imm_signed;
	logic [1:0]  disp_left;
	logic [2:0]  off_left;
	logic        pend_ovr;
	spod_seg_type pend_seg;
	logic        is_prefix;
	logic [1:0]  mod_in;
	logic [2:0]  rm_in;
	logic [1:0]  disp_need;
	logic [1:0]  off_idx;
	logic [2:0]  off_need;
	logic        op_slot;
	logic        str_to_extra;

	assign is_prefix = (BYTE_DATA[`SPOD_PFX_HI_MSB:`SPOD_PFX_HI_LSB] == `SPOD_PFX_HI_VAL) &&
		(BYTE_DATA[`SPOD_PFX_LO_MSB:`SPOD_PFX_LO_LSB] == `SPOD_PFX_LO_VAL);
	assign mod_in = BYTE_DATA[`SPOD_MOD_MSB:`SPOD_MOD_LSB];
	assign rm_in  = BYTE_DATA[`SPOD_RM_MSB:`SPOD_RM_LSB];
	assign off_idx = 2'(`SPOD_CD_BYTES - off_left);
	assign op_slot = (state == SPOD_ST_OPCODE) || (state == SPOD_ST_DONE);
	// set: extra:dest side, clear: data:source side
	assign str_to_extra = BYTE_DATA[`SPOD_STR_DIR_BIT];

	// displacement bytes implied by mod and r/m
	always_comb begin
		case (mod_in)
			`SPOD_MOD_D8:     disp_need = `SPOD_DISP8_BYTES;
			`SPOD_MOD_D16:    disp_need = `SPOD_DISP16_BYTES;
			`SPOD_MOD_NODISP: disp_need = (rm_in == `SPOD_RM_DIRECT) ? `SPOD_DISP16_BYTES : 2'h0;
			default:          disp_need = 2'h0;
		endcase
	end

	// offset bytes by class; the upstream opcode table fixes the class
	always_comb begin
		case (OP_CLASS)
			SPOD_OPC_CD: off_need = `SPOD_CD_BYTES;
			SPOD_OPC_CB: off_need = `SPOD_CB_BYTES;
			default:     off_need = 3'h0;
		endcase
	end

	// sequencer: after opcode, optional address byte and disp, or offset, then imm
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			state      <= SPOD_ST_OPCODE;
			opc        <= SPOD_OPC_NONE;
			imm_left   <= 2'h0;
			imm_total  <= 2'h0;
			imm_signed <= 1'b0;
			disp_left  <= 2'h0;
			off_left   <= 3'h0;
		end else if (BYTE_VALID) begin
			case (state)
				SPOD_ST_DONE,
				SPOD_ST_OPCODE: begin
					if (is_prefix) begin
						// prefixes may stack; only the opcode ends the wait
						state <= SPOD_ST_OPCODE;
					end else begin
						opc        <= OP_CLASS;
						imm_left   <= OP_IMM_BYTES;
						imm_total  <= OP_IMM_BYTES;
						imm_signed <= OP_IMM_SIGNED;
						off_left   <= off_need;
						if (OP_HAS_MODRM)
							state <= SPOD_ST_MODRM;
						else if (off_need != 3'h0)
							state <= SPOD_ST_OFFSET;
						else if (OP_IMM_BYTES != 2'h0)
							state <= SPOD_ST_IMM;
						else
							state <= SPOD_ST_DONE;
					end
				end
				SPOD_ST_MODRM: begin
					disp_left <= disp_need;
					if (disp_need != 2'h0)
						state <= SPOD_ST_DISP;
					else if (imm_left != 2'h0)
						state <= SPOD_ST_IMM;
					else
						state <= SPOD_ST_DONE;
				end
				SPOD_ST_DISP: begin
					disp_left <= disp_left - 2'h1;
					if (disp_left == 2'h1)
						state <= (imm_left != 2'h0) ? SPOD_ST_IMM : SPOD_ST_DONE;
				end
				SPOD_ST_IMM: begin
					imm_left <= imm_left - 2'h1;
					if (imm_left == 2'h1)
						state <= SPOD_ST_DONE;
				end
				SPOD_ST_OFFSET: begin
					off_left <= off_left - 3'h1;
					if (off_left == 3'h1)
						state <= (imm_left != 2'h0) ? SPOD_ST_IMM : SPOD_ST_DONE;
				end
				default: state <= SPOD_ST_OPCODE;
			endcase
		end
	end

	// byte role tagging
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			BYTE_ROLE       <= SPOD_ROLE_NONE;
			BYTE_ROLE_VALID <= 1'b0;
			INSN_DONE       <= 1'b0;
		end else begin
			BYTE_ROLE_VALID <= BYTE_VALID;
			INSN_DONE       <= 1'b0;
			if (BYTE_VALID) begin
				case (state)
					SPOD_ST_DONE,
					SPOD_ST_OPCODE: begin
						BYTE_ROLE <= is_prefix ? SPOD_ROLE_PREFIX : SPOD_ROLE_OPCODE;
						INSN_DONE <= !is_prefix && !OP_HAS_MODRM && OP_IMM_BYTES == 2'h0 &&
							off_need == 3'h0;
					end
					SPOD_ST_MODRM: begin
						BYTE_ROLE <= SPOD_ROLE_MODRM;
						INSN_DONE <= disp_need == 2'h0 && imm_left == 2'h0;
					end
					SPOD_ST_DISP: begin
						BYTE_ROLE <= SPOD_ROLE_DISP;
						INSN_DONE <= disp_left == 2'h1 && imm_left == 2'h0;
					end
					SPOD_ST_IMM: begin
						BYTE_ROLE <= SPOD_ROLE_IMM;
						INSN_DONE <= imm_left == 2'h1;
					end
					SPOD_ST_OFFSET: begin
						BYTE_ROLE <= SPOD_ROLE_OFFSET;
						INSN_DONE <= off_left == 3'h1 && imm_left == 2'h0;
					end
					default: BYTE_ROLE <= SPOD_ROLE_NONE;
				endcase
			end
		end
	end

	// segment override: held until the next instruction's opcode consumes it
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			pend_ovr     <= 1'b0;
			pend_seg     <= SPOD_SEG_DATA;
			SEG_OVERRIDE <= 1'b0;
			SEG_SEL      <= SPOD_SEG_DATA;
		end else if (BYTE_VALID && op_slot) begin
			if (is_prefix) begin
				pend_ovr <= 1'b1;
				pend_seg <= spod_seg_type'(BYTE_DATA[`SPOD_SEL_MSB:`SPOD_SEL_LSB]);
			end else begin
				pend_ovr     <= 1'b0;
				SEG_OVERRIDE <= pend_ovr;
				if (pend_ovr)
					SEG_SEL <= pend_seg;
				else if (OP_CLASS == SPOD_OPC_STR && str_to_extra)
					SEG_SEL <= spod_seg_type'(`SPOD_ES_CODE);
				else
					SEG_SEL <= spod_seg_type'(`SPOD_DS_CODE);
			end
		end
	end

	// opcode, address byte fields and register selection
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			OPCODE           <= 8'h00;
			MOD_FIELD        <= 2'h0;
			AUX_FIELD        <= 3'h0;
			RM_FIELD         <= 3'h0;
			OPCODE_EXT       <= 3'h0;
			OPCODE_EXT_VALID <= 1'b0;
			REG_SEL          <= 3'h0;
			REG_SEL_VALID    <= 1'b0;
			REG_WORD         <= 1'b0;
		end else if (BYTE_VALID) begin
			case (state)
				SPOD_ST_DONE,
				SPOD_ST_OPCODE: if (!is_prefix) begin
					OPCODE           <= BYTE_DATA;
					OPCODE_EXT_VALID <= 1'b0;
					REG_WORD         <= BYTE_DATA[`SPOD_W_BIT];
					if (OP_CLASS == SPOD_OPC_EMBED) begin
						REG_SEL       <= BYTE_DATA[`SPOD_RM_MSB:`SPOD_RM_LSB];
						REG_SEL_VALID <= 1'b1;
						REG_WORD      <= 1'b1;
					end else if (OP_CLASS == SPOD_OPC_STR) begin
						// string index: source for the data side, dest for extra
						REG_SEL       <= str_to_extra ? `SPOD_DI_REG
							: `SPOD_SI_REG;
						REG_SEL_VALID <= 1'b1;
						REG_WORD      <= 1'b1;
					end else begin
						REG_SEL_VALID <= 1'b0;
					end
				end
				SPOD_ST_MODRM: begin
					MOD_FIELD <= mod_in;
					AUX_FIELD <= BYTE_DATA[`SPOD_AUX_MSB:`SPOD_AUX_LSB];
					RM_FIELD  <= rm_in;
					if (opc == SPOD_OPC_EXT) begin
						OPCODE_EXT       <= BYTE_DATA[`SPOD_AUX_MSB:`SPOD_AUX_LSB];
						OPCODE_EXT_VALID <= 1'b1;
					end else if (opc == SPOD_OPC_REG) begin
						// REG_WORD already holds opcode size bit; code maps by it
						REG_SEL       <= BYTE_DATA[`SPOD_AUX_MSB:`SPOD_AUX_LSB];
						REG_SEL_VALID <= 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// displacement, immediate, offset bytes
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			DISP   <= 16'h0000;
			IMM    <= 16'h0000;
			OFFSET <= 32'h0000_0000;
		end else if (BYTE_VALID) begin
			case (state)
				SPOD_ST_MODRM: DISP <= 16'h0000;
				SPOD_ST_DISP: begin
					if (disp_left == 2'h2 || MOD_FIELD == `SPOD_MOD_D8)
						// one-byte disp sign-extends; two-byte fills low first
						DISP <= {{8{BYTE_DATA[`SPOD_SIGN_BIT] & (MOD_FIELD == `SPOD_MOD_D8)}},
							BYTE_DATA};
					else
						DISP <= {BYTE_DATA, DISP[7:0]};
				end
				SPOD_ST_IMM: begin
					if (imm_left == imm_total)
						IMM <= {{8{BYTE_DATA[`SPOD_SIGN_BIT] & imm_signed}}, BYTE_DATA};
					else
						IMM <= {BYTE_DATA, IMM[7:0]};
				end
				SPOD_ST_OFFSET: begin
					if (off_left == `SPOD_CD_BYTES || opc == SPOD_OPC_CB)
						OFFSET <= {24'h000000, BYTE_DATA};
					else
						OFFSET[off_idx*8 +: 8] <= BYTE_DATA;
				end
				default: ;
			endcase
		end
	end
endmodule : spod_decoder
`default_nettype wire

// ### spod_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spod_decoder_chk (
	input wire logic                    MCLK,
	input wire logic                    RST_B,
	input wire logic                    BYTE_VALID,
	input wire logic [7:0]              BYTE_DATA,
	input wire spod_pkg::spod_role_type BYTE_ROLE,
	input wire logic                    BYTE_ROLE_VALID,
	input wire spod_pkg::spod_seg_type  SEG_SEL,
	input wire logic                    SEG_OVERRIDE,
	input wire logic [1:0]              MOD_FIELD,
	input wire logic [2:0]              AUX_FIELD,
	input wire logic [2:0]              RM_FIELD,
	input wire logic [2:0]              OPCODE_EXT,
	input wire logic                    OPCODE_EXT_VALID,
	input wire logic [15:0]             DISP,
	input wire logic                    INSN_DONE
);
	import spod_pkg::*;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	a_role_follows: assert property (BYTE_VALID |=> BYTE_ROLE_VALID)
		else $error("role flag missing");
	a_role_pulse: assert property (!BYTE_VALID |=> !BYTE_ROLE_VALID && !INSN_DONE)
		else $error("role flag without byte");
	a_prefix_shape: assert property (BYTE_ROLE_VALID && BYTE_ROLE == SPOD_ROLE_PREFIX
		|-> $past(BYTE_DATA[7:5]) == 3'h1 && $past(BYTE_DATA[2:0]) == 3'h6) else $error("bad prefix");
	a_seg_prefix: assert property (BYTE_ROLE_VALID && BYTE_ROLE == SPOD_ROLE_OPCODE &&
		$past(BYTE_ROLE_VALID) && $past(BYTE_ROLE) == SPOD_ROLE_PREFIX
		|-> SEG_OVERRIDE && SEG_SEL == $past(BYTE_DATA[4:3], 2)) else $error("segment code");
	a_override_once: assert property (BYTE_ROLE_VALID && BYTE_ROLE == SPOD_ROLE_OPCODE &&
		$past(BYTE_ROLE_VALID) && $past(BYTE_ROLE) != SPOD_ROLE_PREFIX
		|-> !SEG_OVERRIDE) else $error("stale override");
	a_addr_split: assert property (BYTE_ROLE_VALID && BYTE_ROLE == SPOD_ROLE_MODRM
		|-> {MOD_FIELD, AUX_FIELD, RM_FIELD} == $past(BYTE_DATA)) else $error("address split");
	a_ext_field: assert property ($rose(OPCODE_EXT_VALID)
		|-> OPCODE_EXT == $past(BYTE_DATA[5:3]) && BYTE_ROLE == SPOD_ROLE_MODRM)
		else $error("extension");
	a_disp_sext: assert property (BYTE_ROLE_VALID && BYTE_ROLE == SPOD_ROLE_DISP &&
		MOD_FIELD == 2'h1 |-> DISP == {{8{$past(BYTE_DATA[7])}}, $past(BYTE_DATA)})
		else $error("short displacement");
endmodule : spod_decoder_chk
bind spod_decoder spod_decoder_chk i_spod_decoder_chk (.MCLK, .RST_B, .BYTE_VALID, .BYTE_DATA,
	.BYTE_ROLE, .BYTE_ROLE_VALID, .SEG_SEL, .SEG_OVERRIDE, .MOD_FIELD, .AUX_FIELD, .RM_FIELD,
	.OPCODE_EXT, .OPCODE_EXT_VALID, .DISP, .INSN_DONE);
`default_nettype wire

// ### tb_spod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spod_decoder;
	import spod_pkg::*;
	typedef struct packed {
		logic [55:0] b;
		logic [2:0] n;
		spod_opclass_type c;
		logic m;
		logic [1:0] ib;
		logic sg;
		spod_seg_type seg;
		logic ovr, xv;
		logic [2:0] x;
		logic rv;
		logic [2:0] r;
		logic [15:0] d, im;
		logic [31:0] o;
		logic [2:0] k;
	} spod_row_type;
	logic mclk, rst_b, bv, hm, sg, ovr, xv, rv, done;
	logic [7:0] bd;
	logic [1:0] ib;
	logic [2:0] x, rs;
	logic [15:0] disp, imm;
	logic [31:0] off;
	spod_opclass_type cls;
	spod_seg_type seg;
	spod_role_type role, erole;
	logic role_v, rw, ew;
	logic [7:0] opc, eop;
	spod_row_type row;
	spod_row_type rows [10];
	int bad_count = 0;
	int checks_done = 0;
	spod_decoder i_spod_decoder (.MCLK(mclk), .RST_B(rst_b), .BYTE_VALID(bv), .BYTE_DATA(bd),
		.OP_CLASS(cls), .OP_HAS_MODRM(hm), .OP_IMM_BYTES(ib), .OP_IMM_SIGNED(sg),
		.BYTE_ROLE(role), .BYTE_ROLE_VALID(role_v), .SEG_SEL(seg), .SEG_OVERRIDE(ovr),
		.OPCODE(opc), .MOD_FIELD(), .AUX_FIELD(), .RM_FIELD(), .OPCODE_EXT(x),
		.OPCODE_EXT_VALID(xv), .REG_SEL(rs), .REG_SEL_VALID(rv), .REG_WORD(rw), .DISP(disp),
		.IMM(imm), .OFFSET(off),
		.INSN_DONE(done));
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic ok, input string what);
		checks_done++;
		if (!ok) begin
			bad_count++;
			$display("Error %0t: %s mismatch", $time, what);
		end
	endtask : chk
	task automatic put(input logic [7:0] v, input logic val);
		@(posedge mclk);
		#1;
		bv = val;
		bd = v;
	endtask : put
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
	initial begin
		rows = '{
		'{56'h2680_60F0_8500_00, 3'h5, SPOD_OPC_EXT, 1'h1, 2'h1, 1'h1, SPOD_SEG_EXTRA, 1'h1,
			1'h1, 3'h4, 1'h0, 3'h0, 16'hFFF0, 16'hFF85, 32'h0, 3'h3},
		'{56'h2E02_C800_0000_00, 3'h3, SPOD_OPC_REG, 1'h1, 2'h0, 1'h0, SPOD_SEG_CODE, 1'h1,
			1'h0, 3'h0, 1'h1, 3'h1, 16'h0, 16'h0, 32'h0, 3'h0},
		'{56'h3681_8634_1278_56, 3'h7, SPOD_OPC_EXT, 1'h1, 2'h2, 1'h0, SPOD_SEG_STACK, 1'h1,
			1'h1, 3'h0, 1'h0, 3'h0, 16'h1234, 16'h5678, 32'h0, 3'h3},
		'{56'h3E95_0000_0000_00, 3'h2, SPOD_OPC_EMBED, 1'h0, 2'h0, 1'h0, SPOD_SEG_DATA, 1'h1,
			1'h0, 3'h0, 1'h1, 3'h5, 16'h0, 16'h0, 32'h0, 3'h0},
		'{56'hEB80_0000_0000_00, 3'h2, SPOD_OPC_CB, 1'h0, 2'h0, 1'h0, SPOD_SEG_DATA, 1'h0,
			1'h0, 3'h0, 1'h0, 3'h0, 16'h0, 16'h0, 32'h80, 3'h4},
		'{56'hEA78_5634_1200_00, 3'h5, SPOD_OPC_CD, 1'h0, 2'h0, 1'h0, SPOD_SEG_DATA, 1'h0,
			1'h0, 3'h0, 1'h0, 3'h0, 16'h0, 16'h0, 32'h12345678, 3'h4},
		'{56'hA400_0000_0000_00, 3'h1, SPOD_OPC_STR, 1'h0, 2'h0, 1'h0, SPOD_SEG_DATA, 1'h0,
			1'h0, 3'h0, 1'h1, 3'h6, 16'h0, 16'h0, 32'h0, 3'h0},
		'{56'hAA00_0000_0000_00, 3'h1, SPOD_OPC_STR, 1'h0, 2'h0, 1'h0, SPOD_SEG_EXTRA, 1'h0,
			1'h0, 3'h0, 1'h1, 3'h7, 16'h0, 16'h0, 32'h0, 3'h0},
		'{56'h0485_0000_0000_00, 3'h2, SPOD_OPC_NONE, 1'h0, 2'h1, 1'h0, SPOD_SEG_DATA, 1'h0,
			1'h0, 3'h0, 1'h0, 3'h0, 16'h0, 16'h0085, 32'h0, 3'h2},
		'{56'h8F06_0080_0000_00, 3'h4, SPOD_OPC_NONE, 1'h1, 2'h0, 1'h0, SPOD_SEG_DATA, 1'h0,
			1'h0, 3'h0, 1'h0, 3'h0, 16'h8000, 16'h0, 32'h0, 3'h1}};
		{bv, bd, hm, ib, sg, rst_b} = '0;
		cls = SPOD_OPC_NONE;
		repeat (10) @(posedge mclk);
		#1;
		rst_b = 1'h1;
		for (int i = 0; i < 10; i++) begin
			row = rows[i];
			cls = row.c;
			{hm, ib, sg} = {row.m, row.ib, row.sg};
			for (int j = 0; j < int'(row.n); j++) put(row.b[55 - 8 * j -: 8], 1'h1);
			put(8'h00, 1'h0);
			eop = row.b[55 - 8 * int'(row.ovr) -: 8];
			ew = (row.c == SPOD_OPC_REG) ? eop[0] : 1'h1;
			erole = row.k[1] ? SPOD_ROLE_IMM : row.k[2] ? SPOD_ROLE_OFFSET :
				row.k[0] ? SPOD_ROLE_DISP : row.m ? SPOD_ROLE_MODRM : SPOD_ROLE_OPCODE;
			chk(done === 1'h1, "done");
			chk(role_v === 1'h1 && role === erole, "role");
			chk(opc === eop, "opcode");
			chk(!row.rv || rw === ew, "size");
			chk(seg === row.seg, "segment");
			chk(ovr === row.ovr, "override");
			chk(xv === row.xv && (!row.xv || x === row.x), "extension");
			chk(rv === row.rv && (!row.rv || rs === row.r), "register");
			if (row.k[0]) chk(disp === row.d, "disp");
			if (row.k[1]) chk(imm === row.im, "imm");
			if (row.k[2]) chk(off === row.o, "offset");
		end
		$display("table rows done");
		// two prefixes, then a gap before the opcode: the later prefix must win
		put(8'h26, 1'h1);
		put(8'h3E, 1'h1);
		put(8'h00, 1'h0);
		cls = SPOD_OPC_NONE;
		{hm, ib, sg} = '0;
		put(8'h90, 1'h1);
		put(8'h00, 1'h0);
		chk(seg === SPOD_SEG_DATA && ovr === 1'h1, "last prefix");
		chk(opc === 8'h90 && role === SPOD_ROLE_OPCODE, "opcode after prefixes");
		$display("prefix chain done");
		rst_b = 1'h0;
		repeat (2) put(8'h00, 1'h0);
		chk(seg === SPOD_SEG_DATA && ovr === 1'h0 && off === 32'h0 && done === 1'h0, "reset");
		chk(imm === 16'h0 && disp === 16'h0 && opc === 8'h00 && role_v === 1'h0, "reset");
		rst_b = 1'h1;
		put(8'h90, 1'h1);
		put(8'h00, 1'h0);
		chk(done === 1'h1 && role === SPOD_ROLE_OPCODE && ovr === 1'h0, "after reset");
		$display("reset test done");
		end_sim();
	end
endmodule : tb_spod_decoder
`default_nettype wire
